// File: verilog/smn_defs.vh
// Purpose: Constants for the signed multiply and negate unit.
// Assumes: Included by the unit's design file and by its self-checking bench.
// Notes: Offsets are byte addresses on a 32-bit classic Wishbone slave.
`ifndef SMN_DEFS_VH
`define SMN_DEFS_VH

// ************************************************************
// Register byte offsets.
// ************************************************************
`define SMN_ADR_CTRL 8'h00
`define SMN_ADR_DST_LO 8'h04
`define SMN_ADR_DST_HI 8'h08
`define SMN_ADR_SRC 8'h0c
`define SMN_ADR_FLAGS 8'h10
`define SMN_ADR_STATUS 8'h14
`define SMN_ADR_CYCLES 8'h18

// ************************************************************
// Control register fields.
// ************************************************************
`define SMN_CTRL_OP_LSB 0
`define SMN_CTRL_OP_MSB 1
`define SMN_CTRL_BYTE 2
`define SMN_CTRL_MODE_LSB 4
`define SMN_CTRL_MODE_MSB 6
`define SMN_CTRL_SEG_LSB 8
`define SMN_CTRL_SEG_MSB 9
`define SMN_CTRL_START 31
`define SMN_CTRL_MASK 32'h0000_0377

// Operation codes.
`define SMN_OP_MUL_WORD 2'h0
`define SMN_OP_MUL_LONG 2'h1
`define SMN_OP_NEGATE 2'h2

// Source or operand addressing modes.
`define SMN_MODE_REG 3'h0
`define SMN_MODE_LITERAL 3'h1
`define SMN_MODE_POINTER 3'h2
`define SMN_MODE_ABSOLUTE 3'h3
`define SMN_MODE_INDEXED 3'h4

// Address space forms: non-segmented, short and long segmented.
`define SMN_SEG_NS 2'h0
`define SMN_SEG_SS 2'h1

// ************************************************************
// Flag bit positions and status bits.
// ************************************************************
`define SMN_FLAG_C 0
`define SMN_FLAG_Z 1
`define SMN_FLAG_S 2
`define SMN_FLAG_V 3
`define SMN_FLAG_D 4
`define SMN_FLAG_H 5
`define SMN_STAT_BUSY 0
`define SMN_STAT_DONE 1
`define SMN_STAT_ERR 2

// ************************************************************
// Execution times in core cycles.
// ************************************************************
`define SMN_CYC_MULW 10'd70
`define SMN_CYC_MULW_ZERO 10'd18
`define SMN_CYC_MULL 10'd282
`define SMN_CYC_MULL_BIT 10'd7
`define SMN_CYC_MULL_ZERO 10'd30
`define SMN_CYC_NEG_REG 10'd7
`define SMN_CYC_NEG_PTR 10'd12
`define SMN_CYC_NEG_MEM 10'd14
`define SMN_CYC_ABS_NS 10'd1
`define SMN_CYC_ABS_SS 10'd2
`define SMN_CYC_ABS_SL 10'd4
`define SMN_CYC_IDX_NS 10'd2
`define SMN_CYC_IDX_SS 10'd2
`define SMN_CYC_IDX_SL 10'd5
`define SMN_CYC_IDX_SL_WZ 10'd4

`endif

// File: verilog/smn_signed_multiply_negate_unit.v
// Purpose: Signed multiply (word and long) and two's-complement negate datapath.
// Assumes: One 50 MHz core clock, synchronous active-high reset, classic Wishbone.
// Notes: Results are written back into the destination registers when the
// modelled execution time has elapsed.
//
// Overview of operation
// [RULE1] Low destination half times source, full product stored.
// [RULE2] Both multiply operands are signed two's complement.
// [RULE3] Word: pair and word; long: quadruple and long.
// [RULE4] Word carry when product outside signed 16 bits.
// [RULE5] Long carry when product outside signed 32 bits.
// [RULE6] Multiply: Z, S from result; V cleared; D, H kept.
// [RULE7] Multiply times 70, 282+7n; zero multiplier 18, 30.
// [RULE8] Producer keeps destination and source fields aligned.
// [RULE9] Destination is register; source in five modes.
// [RULE10] Negate replaces word or byte with two's complement.
// [RULE11] Most negative value negates to itself.
// [RULE12] Negate V set for 8000 or 80 result.
// [RULE13] Negate carry clear on zero result, else set.
// [RULE14] Negate: Z, S from result; D, H kept.
// [RULE15] Negate takes 7 register, 12 pointer cycles.
// [RULE16] Width bit selects word or byte negate.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "smn_defs.vh"

module smn_signed_multiply_negate_unit (
    // Clock and reset.
    input wire clock_i,
    input wire srst_i,
    // Wishbone slave.
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Execution status.
    output reg busy_o
);

    // ************************************************************
    // State registers.
    // ************************************************************
    reg [31:0] ctrl_reg;     // Operation, width, mode and address form.
    reg [31:0] dst_lo_reg;   // Destination low long word (pair, or low half of quadruple).
    reg [31:0] dst_hi_reg;   // Destination high long word of a quadruple.
    reg [31:0] src_reg;      // Source operand, never modified by execution.
    reg [5:0] flags_reg;     // Flag register C, Z, S, V, D, H.
    reg done_reg;            // Last start request was accepted and its operation has completed.
    reg err_reg;             // Last start request named an illegal form.
    reg [9:0] count_reg;     // Remaining execution cycles minus one.
    reg [9:0] cycles_reg;    // Execution time of the last accepted operation.

    // Decoded control fields.
    wire [1:0] op = ctrl_reg[`SMN_CTRL_OP_MSB:`SMN_CTRL_OP_LSB];
    wire is_byte = ctrl_reg[`SMN_CTRL_BYTE];
    wire [2:0] mode = ctrl_reg[`SMN_CTRL_MODE_MSB:`SMN_CTRL_MODE_LSB];
    wire [1:0] seg = ctrl_reg[`SMN_CTRL_SEG_MSB:`SMN_CTRL_SEG_LSB];

    // ************************************************************
    // Bus decode.
    // ************************************************************
    // A request is answered one cycle after it appears, and the ack is
    // dropped again in the next cycle so a held request is not taken twice.
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i;
    wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire start_req = bus_wr & (wb_adr_i == `SMN_ADR_CTRL) & wb_sel_i[3]
                     & wb_dat_i[`SMN_CTRL_START];

    // ************************************************************
    // Multiply datapath.
    // ************************************************************
    // Both operands are sign extended so the products are exact.
    wire signed [15:0] mw_a = dst_lo_reg[15:0];        // see [RULE1]
    wire signed [15:0] mw_b = src_reg[15:0];           // see [RULE3]
    wire signed [31:0] ml_a = dst_lo_reg;              // see [RULE3]
    wire signed [31:0] ml_b = src_reg;
    wire signed [31:0] prod_w = mw_a * mw_b;           // see [RULE2]
    wire signed [63:0] prod_l = ml_a * ml_b;           // see [RULE2]

    // Out of signed range when the result's sign bit and the bits above it disagree.
    wire carry_w = ~((&prod_w[31:15]) | ~(|prod_w[31:15]));  // see [RULE4]
    wire carry_l = ~((&prod_l[63:31]) | ~(|prod_l[63:31]));  // see [RULE5]

    // ************************************************************
    // Negate datapath.
    // ************************************************************
    // Plain modular negation maps 8000 and 80 onto themselves.
    wire [15:0] neg_w = 16'h0000 - dst_lo_reg[15:0];   // see [RULE10] [RULE11]
    wire [7:0] neg_b = 8'h00 - dst_lo_reg[7:0];        // see [RULE11]

    // ************************************************************
    // Bit count of the absolute low 16 destination bits.
    // ************************************************************
    wire [15:0] abs_lo = dst_lo_reg[15] ? (16'h0000 - dst_lo_reg[15:0]) : dst_lo_reg[15:0];
    wire [4:0] ones_acc [0:16];
    assign ones_acc[0] = 5'h00;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_ones
            assign ones_acc[gi + 1] = ones_acc[gi] + {4'h0, abs_lo[gi]};
        end
    endgenerate

    // ************************************************************
    // Execution time table.
    // ************************************************************
    // Memory forms add a fixed penalty per address form on a mode base.
    reg [9:0] mem_extra;
    reg [9:0] exec_cycles;
    reg form_ok;
    wire signed_product_word_zero_w = (src_reg[15:0] == 16'h0000);
    wire signed_product_word_zero_l = (src_reg == 32'h0000_0000);
    always @* begin
        mem_extra = 10'd0;
        if (mode == `SMN_MODE_ABSOLUTE) begin
            if (seg == `SMN_SEG_NS) begin
                mem_extra = `SMN_CYC_ABS_NS;
            end else if (seg == `SMN_SEG_SS) begin
                mem_extra = `SMN_CYC_ABS_SS;
            end else begin
                mem_extra = `SMN_CYC_ABS_SL;
            end
        end else if (mode == `SMN_MODE_INDEXED) begin
            if (seg == `SMN_SEG_NS) begin
                mem_extra = `SMN_CYC_IDX_NS;
            end else if (seg == `SMN_SEG_SS) begin
                mem_extra = `SMN_CYC_IDX_SS;
            end else if (op == `SMN_OP_MUL_WORD && signed_product_word_zero_w) begin
                // A word multiply with a zero multiplier pays one cycle less in the long segmented form.
                mem_extra = `SMN_CYC_IDX_SL_WZ;
            end else begin
                mem_extra = `SMN_CYC_IDX_SL;
            end
        end
    end

    always @* begin
        exec_cycles = `SMN_CYC_NEG_REG;
        form_ok = (mode <= `SMN_MODE_INDEXED);          // see [RULE9]
        case (op)
            `SMN_OP_MUL_WORD: begin
                exec_cycles = (signed_product_word_zero_w ? `SMN_CYC_MULW_ZERO : `SMN_CYC_MULW)
                              + mem_extra;              // see [RULE7]
            end
            `SMN_OP_MUL_LONG: begin
                exec_cycles = (signed_product_word_zero_l ? `SMN_CYC_MULL_ZERO :
                              `SMN_CYC_MULL + `SMN_CYC_MULL_BIT * {5'h00, ones_acc[16]})
                              + mem_extra;              // see [RULE7]
            end
            `SMN_OP_NEGATE: begin
                // A negate has no literal form: it writes its operand.
                form_ok = form_ok & (mode != `SMN_MODE_LITERAL);
                if (mode == `SMN_MODE_REG) begin
                    exec_cycles = `SMN_CYC_NEG_REG;     // see [RULE15]
                end else if (mode == `SMN_MODE_POINTER) begin
                    exec_cycles = `SMN_CYC_NEG_PTR;     // see [RULE15]
                end else begin
                    exec_cycles = `SMN_CYC_NEG_MEM + mem_extra;  // see [RULE15]
                end
            end
            default: begin
                form_ok = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Write-back values and flags at completion.
    // ************************************************************
    reg [31:0] wb_lo;
    reg [31:0] wb_hi;
    reg [5:0] flags_new;
    always @* begin
        wb_lo = dst_lo_reg;
        wb_hi = dst_hi_reg;
        flags_new = flags_reg;                          // see [RULE6] [RULE14]
        case (op)
            `SMN_OP_MUL_WORD: begin
                wb_lo = prod_w;                         // see [RULE1] [RULE3]
                flags_new[`SMN_FLAG_C] = carry_w;       // see [RULE4]
                flags_new[`SMN_FLAG_Z] = (prod_w == 32'h0000_0000);  // see [RULE6]
                flags_new[`SMN_FLAG_S] = prod_w[31];    // see [RULE6]
                flags_new[`SMN_FLAG_V] = 1'b0;          // see [RULE6]
            end
            `SMN_OP_MUL_LONG: begin
                wb_lo = prod_l[31:0];                   // see [RULE1] [RULE3]
                wb_hi = prod_l[63:32];
                flags_new[`SMN_FLAG_C] = carry_l;       // see [RULE5]
                flags_new[`SMN_FLAG_Z] = (prod_l == 64'h0000_0000_0000_0000);  // see [RULE6]
                flags_new[`SMN_FLAG_S] = prod_l[63];    // see [RULE6]
                flags_new[`SMN_FLAG_V] = 1'b0;          // see [RULE6]
            end
            `SMN_OP_NEGATE: begin
                if (is_byte) begin
                    wb_lo = {dst_lo_reg[31:8], neg_b};  // see [RULE16]
                    flags_new[`SMN_FLAG_C] = (neg_b != 8'h00);     // see [RULE13]
                    flags_new[`SMN_FLAG_Z] = (neg_b == 8'h00);     // see [RULE14]
                    flags_new[`SMN_FLAG_S] = neg_b[7];             // see [RULE14]
                    flags_new[`SMN_FLAG_V] = (neg_b == 8'h80);     // see [RULE12]
                end else begin
                    wb_lo = {dst_lo_reg[31:16], neg_w}; // see [RULE10] [RULE16]
                    flags_new[`SMN_FLAG_C] = (neg_w != 16'h0000);  // see [RULE13]
                    flags_new[`SMN_FLAG_Z] = (neg_w == 16'h0000);  // see [RULE14]
                    flags_new[`SMN_FLAG_S] = neg_w[15];            // see [RULE14]
                    flags_new[`SMN_FLAG_V] = (neg_w == 16'h8000);  // see [RULE12]
                end
            end
            default: begin
                wb_lo = dst_lo_reg;
            end
        endcase
    end

    // ************************************************************
    // Execution sequencer and register file.
    // ************************************************************
    // Operand and control writes are ignored while busy; this keeps the
    // datapath inputs stable so the result needs no snapshot registers.
    always @(posedge clock_i) begin
        if (srst_i) begin
            ctrl_reg <= 32'h0000_0000;
            dst_lo_reg <= 32'h0000_0000;
            dst_hi_reg <= 32'h0000_0000;
            src_reg <= 32'h0000_0000;
            flags_reg <= 6'h00;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            count_reg <= 10'd0;
            cycles_reg <= 10'd0;
            busy_o <= 1'b0;
        end else if (busy_o) begin
            if (count_reg == 10'd0) begin
                // Completion: the source register is never touched.
                dst_lo_reg <= wb_lo;
                dst_hi_reg <= wb_hi;
                flags_reg <= flags_new;
                busy_o <= 1'b0;
                done_reg <= 1'b1;
            end else begin
                count_reg <= count_reg - 10'd1;
            end
        end else begin
            if (bus_wr) begin
                case (wb_adr_i)
                    `SMN_ADR_CTRL: begin
                        ctrl_reg <= ((ctrl_reg & ~lane_mask) | (wb_dat_i & lane_mask))
                                    & `SMN_CTRL_MASK;
                    end
                    `SMN_ADR_DST_LO: begin
                        dst_lo_reg <= (dst_lo_reg & ~lane_mask) | (wb_dat_i & lane_mask);
                    end
                    `SMN_ADR_DST_HI: begin
                        dst_hi_reg <= (dst_hi_reg & ~lane_mask) | (wb_dat_i & lane_mask);
                    end
                    `SMN_ADR_SRC: begin
                        src_reg <= (src_reg & ~lane_mask) | (wb_dat_i & lane_mask);
                    end
                    `SMN_ADR_FLAGS: begin
                        flags_reg <= (flags_reg & ~lane_mask[5:0]) | (wb_dat_i[5:0] & lane_mask[5:0]);
                    end
                    default: begin
                        // Read-only or unmapped: the write is dropped.
                        count_reg <= count_reg;
                    end
                endcase
            end
            // The start bit acts on the control already held, so software
            // sets the fields in one write and starts in a later one.
            if (start_req) begin
                done_reg <= 1'b0;
                err_reg <= ~form_ok;
                if (form_ok) begin
                    busy_o <= 1'b1;
                    count_reg <= exec_cycles - 10'd1;   // see [RULE7] [RULE15]
                    cycles_reg <= exec_cycles;
                end
            end
        end
    end

    // ************************************************************
    // Bus answer.
    // ************************************************************
    // Every request, mapped or not, is acked once; unmapped reads give zero.
    always @(posedge clock_i) begin
        if (srst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `SMN_ADR_CTRL: wb_dat_o <= ctrl_reg;
                    `SMN_ADR_DST_LO: wb_dat_o <= dst_lo_reg;
                    `SMN_ADR_DST_HI: wb_dat_o <= dst_hi_reg;
                    `SMN_ADR_SRC: wb_dat_o <= src_reg;
                    `SMN_ADR_FLAGS: wb_dat_o <= {26'h000_0000, flags_reg};
                    `SMN_ADR_STATUS: wb_dat_o <= {29'h0000_0000, err_reg, done_reg, busy_o};
                    `SMN_ADR_CYCLES: wb_dat_o <= {22'h00_0000, cycles_reg};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

endmodule // smn_signed_multiply_negate_unit

// File: tb/smn_signed_multiply_negate_unit_assertions.sv
// Purpose: Port-level checks for the signed multiply and negate unit.
// Assumes: One core clock with a synchronous active-high reset.
// Notes: Times are checked as per-operation ranges; exact values are the bench's job.
`timescale 1ns/100ps

module smn_unit_checker (
    // Clock and reset.
    input wire clock_i,
    input wire srst_i,
    // Wishbone slave.
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Execution status.
    input wire busy_o
);
    // ************************************************************
    // Helper state.
    // ************************************************************
    reg [1:0] op_reg; // Operation last written without the start bit.
    reg [9:0] busy_cnt_reg; // Cycles spent busy in the current run.

    // Only idle writes are tracked, because writes during a run are dropped.
    always @(posedge clock_i) begin
        if (srst_i) begin
            op_reg <= 2'h0;
            busy_cnt_reg <= 10'h000;
        end else begin
            busy_cnt_reg <= busy_o ? busy_cnt_reg + 10'h001 : 10'h000;
            if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !busy_o &&
                wb_adr_i == 8'h00 && !wb_dat_i[31]) begin
                op_reg <= wb_dat_i[1:0];
            end
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    ack_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered in one cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    busy_min_a: assert property ($rose(busy_o) |-> busy_o [*7])
        else $error("run shorter than seven cycles");
    busy_max_a: assert property ($rose(busy_o) |-> ##[7:400] !busy_o)
        else $error("run never ends");
    busy_cause_a: assert property ($rose(busy_o) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[31]))
        else $error("run began without start write");
    word_time_a: assert property (($fell(busy_o) && op_reg == 2'h0) |->
        busy_cnt_reg inside {[10'h012:10'h04b]})
        else $error("word multiply time out of range");
    long_time_a: assert property (($fell(busy_o) && op_reg == 2'h1) |->
        busy_cnt_reg inside {[10'h01e:10'h18f]})
        else $error("long multiply time out of range");
    neg_time_a: assert property (($fell(busy_o) && op_reg == 2'h2) |->
        busy_cnt_reg inside {[10'h007:10'h013]})
        else $error("negate time out of range");
endmodule // smn_unit_checker

// File: tb/smn_signed_multiply_negate_unit_tb.sv
// Purpose: Self-checking bench for the signed multiply and negate unit.
// Assumes: The operand of every source mode is taken from the SRC register.
// Notes: A behavioural model predicts results, flags, status and execution times.
`timescale 1ns/100ps
`include "smn_defs.vh"

module smn_signed_multiply_negate_unit_tb;
    // ************************************************************
    // Signals and counters.
    // ************************************************************
    logic clock_i = 1'b0, srst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, r;
    logic wb_ack_o, busy_o;
    integer fails = 0, comparisons = 0, seed = 16, i;

    always #10 clock_i = ~clock_i; // A 50 MHz core clock.

    smn_signed_multiply_negate_unit uut (.clock_i(clock_i), .srst_i(srst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .busy_o(busy_o));

    // Compares one value and counts the outcome.
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %0t ns value %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle, held until ack is sampled, then one idle cycle.
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        // Only the watchdog ends a wait that never sees ack.
        do begin
            @(posedge clock_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock_i);
    endtask

    // ************************************************************
    // One operation against the model; poke writes DST_LO mid-run.
    // ************************************************************
    task run(input logic [1:0] op, input logic byt, input logic [2:0] md, input logic [1:0] fm,
        input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] src, input logic poke);
        longint p;
        logic [31:0] elo, ehi;
        logic [15:0] w;
        logic [5:0] pre, ef;
        integer n, ext, k;
        logic bad;
        pre = $random(seed);
        bad = op == 2'h3 || md > 3'h4 || (op == 2'h2 && md == 3'h1);
        ext = md == 3'h3 ? (fm == 2'h0 ? 1 : fm == 2'h1 ? 2 : 4) : md == 3'h4 ? (fm[1] ? 5 : 2) : 0;
        w = lo[15] ? -lo[15:0] : lo[15:0];
        ehi = hi;
        if (op == 2'h0) begin
            p = $signed(lo[15:0]) * $signed(src[15:0]);
            elo = p[31:0];
            n = src[15:0] == 16'h0 ? 18 + ((md == 3'h4 && fm[1]) ? 4 : ext) : 70 + ext;
            ef = {pre[5:4], 1'b0, p < 0, p == 0, p < -32768 || p >= 32768};
        end else if (op == 2'h1) begin
            p = $signed(lo) * $signed(src);
            {ehi, elo} = p;
            n = (src == 32'h0 ? 30 : 282 + 7 * $countones(w)) + ext;
            ef = {pre[5:4], 1'b0, p < 0, p == 0, p < -64'sd2147483648 || p > 64'sd2147483647};
        end else begin
            elo = byt ? {lo[31:8], -lo[7:0]} : {lo[31:16], -lo[15:0]};
            w = byt ? {8'h00, elo[7:0]} : elo[15:0];
            n = md == 3'h0 ? 7 : md == 3'h2 ? 12 : 14 + ext;
            ef = {pre[5:4], w == (byt ? 16'h0080 : 16'h8000), byt ? w[7] : w[15], w == 0, w != 0};
        end
        // The pair and the quadruple always start at an aligned register slot.
        wb(1'b1, `SMN_ADR_DST_LO, lo, rd);
        wb(1'b1, `SMN_ADR_DST_HI, hi, rd);
        wb(1'b1, `SMN_ADR_SRC, src, rd);
        wb(1'b1, `SMN_ADR_FLAGS, {26'h0, pre}, rd);
        wb(1'b1, `SMN_ADR_CTRL, {22'h0, fm, 1'b0, md, 1'b0, byt, op}, rd);
        wb(1'b1, `SMN_ADR_CTRL, {1'b1, 21'h0, fm, 1'b0, md, 1'b0, byt, op}, rd);
        k = 2;
        if (poke) begin
            wb(1'b1, `SMN_ADR_DST_LO, ~lo, rd);
            k = k + 3;
        end
        while (busy_o === 1'b1) begin
            @(posedge clock_i);
            k = k + 1;
        end
        wb(1'b0, `SMN_ADR_STATUS, 32'h0, rd);
        chk(rd, bad ? 32'h4 : 32'h2);
        wb(1'b0, `SMN_ADR_DST_LO, 32'h0, rd);
        chk(rd, bad ? lo : elo);
        wb(1'b0, `SMN_ADR_DST_HI, 32'h0, rd);
        chk(rd, bad ? hi : ehi);
        wb(1'b0, `SMN_ADR_SRC, 32'h0, rd);
        chk(rd, src);
        wb(1'b0, `SMN_ADR_FLAGS, 32'h0, rd);
        chk(rd, {26'h0, bad ? pre : ef});
        if (!bad) begin
            wb(1'b0, `SMN_ADR_CYCLES, 32'h0, rd);
            chk(rd, n);
            chk(k - 1, n);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        // Every register and one unmapped offset read zero after reset.
        for (i = 0; i <= 28; i = i + 4) begin
            wb(1'b0, 8'(i), 32'h0, rd);
            chk(rd, 32'h0);
        end
        $display("test reset values done");
        // Carry bounds, zero multipliers, extremes and refused forms.
        run(2'h0, 1'b0, 3'h0, 2'h0, 32'h8000, 32'h0, 32'h8000, 1'b0);
        run(2'h0, 1'b0, 3'h1, 2'h0, 32'hffff, 32'h0, 32'h8000, 1'b0);
        run(2'h0, 1'b0, 3'h2, 2'h0, 32'h0001, 32'h0, 32'h8000, 1'b0);
        run(2'h0, 1'b0, 3'h4, 2'h2, 32'h1234, 32'h0, 32'h0, 1'b0);
        run(2'h1, 1'b0, 3'h1, 2'h0, 32'h31, 32'h22222222, 32'd10, 1'b0);
        run(2'h1, 1'b0, 3'h0, 2'h0, 32'h80000000, 32'h0, 32'h80000000, 1'b1);
        run(2'h1, 1'b0, 3'h0, 2'h0, 32'h80000000, 32'h0, 32'h1, 1'b0);
        run(2'h1, 1'b0, 3'h3, 2'h2, 32'h8000, 32'h0, 32'h0, 1'b0);
        run(2'h2, 1'b0, 3'h0, 2'h0, 32'h00ab8000, 32'h0, 32'h0, 1'b0);
        run(2'h2, 1'b1, 3'h2, 2'h0, 32'h0000cd80, 32'h0, 32'h0, 1'b0);
        run(2'h2, 1'b0, 3'h3, 2'h1, 32'h0, 32'h0, 32'h0, 1'b0);
        run(2'h2, 1'b1, 3'h4, 2'h2, 32'h1234001f, 32'h0, 32'h0, 1'b0);
        run(2'h3, 1'b0, 3'h0, 2'h0, 32'h5, 32'h0, 32'h3, 1'b0);
        run(2'h2, 1'b0, 3'h1, 2'h0, 32'h5, 32'h0, 32'h3, 1'b0);
        run(2'h0, 1'b0, 3'h5, 2'h0, 32'h5, 32'h0, 32'h3, 1'b0);
        $display("test edge cases done");
        for (i = 0; i < 24; i = i + 1) begin
            r = $random(seed);
            run(2'(i % 3), r[3], r[6:4] % 3'h5, r[9:8] % 2'h3, $random(seed), $random(seed),
                r[31:30] != 2'h0 ? $random(seed) : 32'h0, 1'b0);
        end
        $display("test random operations done");
        final_report;
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #1200000;
        fails = fails + 1;
        final_report;
    end
endmodule // smn_signed_multiply_negate_unit_tb

bind smn_signed_multiply_negate_unit smn_unit_checker chk_u (.clock_i(clock_i),
    .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .busy_o(busy_o));
